// ===== hdl/cpc_protect.sv
// cell protection controller: fault qualification, FET gate drive, regs
// assumes comparator levels arrive asynchronously from the analog front end
// Notes on behaviour
// - faults are watched only in Active mode.
// - overvoltage after delay turns charge gate off, sets high flag.
// - charge gate returns below enable level or on discharge below limit.
// - undervoltage after delay turns both gates off; may enter Sleep.
// - recovery charge path on while cell below limit minus 100mV.
// - charger seen in undervoltage waits for cell at limit, then Active.
// - without sleep, both gates return once cell exceeds low limit.
// - charge overcurrent after delay turns both gates off, sets flag.
// - charge surge pulls pack sense down; release when it falls low.
// - discharge overcurrent after delay turns drain gate off, sets flag.
// - short circuit after delay does the same, same flag.
// - discharge surge pulls pack sense up; release when it rises high.
// - gate outputs are the AND of fault-free terms and allow bits.
// - bits 7..4 set by hardware; bits 7, 5, 4 written 0 clear, 1 keeps.
// - high and surge flags clear on reset and on entering Sleep.
// - bit 6 mirrors status low flag, cleared by the status low clear input.
// - bits 3 and 2 read the present gate driver states.
// - allow bits set on reset and on wake; software may clear.
// - a clear allow bit forces its gate low.
// - threshold register fields go out to the comparators.
// - undervoltage sleeps only if allowed and bus stable long enough.
`timescale 1ns/10ps
`include "cpc_params.svh"
module cpc_protect #(
	parameter int OVD_CYC = `CPC_US2CYC(`CPC_OVD_US),
	parameter int UVD_CYC = `CPC_US2CYC(`CPC_UVD_US),
	parameter int OCD_CYC = `CPC_US2CYC(`CPC_OCD_US),
	parameter int SCD_CYC = `CPC_US2CYC(`CPC_SCD_US),
	parameter int SLEEPQ_CYC = `CPC_US2CYC(`CPC_SLEEPQ_US)
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cell_above_high_i,
	input wire logic cell_below_ce_i,
	input wire logic cell_below_low_i,
	input wire logic cell_below_rc_i,
	input wire logic sense_charge_surge_i,
	input wire logic sense_discharge_surge_i,
	input wire logic sense_short_i,
	input wire logic sense_discharging_i,
	input wire logic pack_plus_low_i,
	input wire logic pack_plus_high_i,
	input wire logic charger_seen_i,
	input wire logic bus_line_i,
	input wire logic low_cell_sleep_allow_i,
	input wire logic status_low_clear_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	output logic charge_gate_out_o,
	output logic drain_gate_out_o,
	output logic pack_pulldown_o,
	output logic pack_pullup_o,
	output logic recovery_path_o,
	output logic status_low_cell_flag_o,
	output logic sleep_o,
	output logic [4:0] high_limit_sel_o,
	output logic short_limit_sel_o,
	output logic [1:0] surge_limit_sel_o
);
	if (OVD_CYC < 1 || UVD_CYC < 1 || OCD_CYC < 1 || SCD_CYC < 1 ||
			SLEEPQ_CYC < 1) begin : g_bad_delay
		$error("cpc_protect: delay counts must be at least one");
	end

	localparam int NIN = 14;
	localparam int NQ = 4;
	localparam int CW = 32;

	// two-stage synchronisers for every analog comparator and pin except the register bus inputs
	logic [NIN-1:0] raw_in;
	logic [NIN-1:0] s1_reg, s2_reg;
	assign raw_in = {cell_above_high_i, cell_below_ce_i, cell_below_low_i,
		cell_below_rc_i, sense_charge_surge_i, sense_discharge_surge_i,
		sense_short_i, sense_discharging_i, pack_plus_low_i,
		pack_plus_high_i, charger_seen_i, bus_line_i,
		low_cell_sleep_allow_i, status_low_clear_i};
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s1_reg <= '0;
			s2_reg <= '0;
		end else begin
			s1_reg <= raw_in;
			s2_reg <= s1_reg;
		end
	end
	logic ov_c, ce_c, uv_c, rc_c, coc_c, doc_c, sc_c, dis_c;
	logic plo_c, phi_c, chg_c, bus_c, lsa_c, uvclr_c;
	assign {ov_c, ce_c, uv_c, rc_c, coc_c, doc_c, sc_c, dis_c,
		plo_c, phi_c, chg_c, bus_c, lsa_c, uvclr_c} = s2_reg;

	cpc_pkg::cpc_mode_t mode_reg, mode_next;
	logic active;
	assign active = (mode_reg == cpc_pkg::CPC_ACTIVE);

	// qualification counters: 0 undervoltage, 1 charge surge, 2 discharge surge, 3 short
	logic [NQ-1:0] cond;
	logic [NQ-1:0] qual;
	logic [CW-1:0] lim [NQ];
	assign cond = {sc_c, doc_c, coc_c, uv_c} & {NQ{active}};
	assign lim[0] = CW'(UVD_CYC);
	assign lim[1] = CW'(OCD_CYC);
	assign lim[2] = CW'(OCD_CYC);
	assign lim[3] = CW'(SCD_CYC);
	logic [CW-1:0] ov_cnt_reg, ov_cnt_next;
	logic ov_qual;
	genvar gi;
	generate
		for (gi = 0; gi < NQ; gi++) begin : g_qual
			logic [CW-1:0] cnt_reg, cnt_next;
			always_comb begin
				cnt_next = '0;
				if (cond[gi] && cnt_reg < lim[gi])
					cnt_next = cnt_reg + CW'(1);
				else if (cond[gi])
					cnt_next = cnt_reg;
			end
			always_ff @(posedge clk_i or posedge rst_i) begin
				if (rst_i)
					cnt_reg <= '0;
				else
					cnt_reg <= cnt_next;
			end
			assign qual[gi] = cond[gi] && cnt_reg >= lim[gi];
		end
	endgenerate
	always_comb begin
		ov_cnt_next = '0;
		if (ov_c && active && ov_cnt_reg < CW'(OVD_CYC))
			ov_cnt_next = ov_cnt_reg + CW'(1);
		else if (ov_c && active)
			ov_cnt_next = ov_cnt_reg;
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			ov_cnt_reg <= '0;
		else
			ov_cnt_reg <= ov_cnt_next;
	end
	assign ov_qual = ov_c && active && ov_cnt_reg >= CW'(OVD_CYC);

	// bus stability counter for undervoltage sleep
	logic [CW-1:0] bus_cnt_reg, bus_cnt_next;
	logic bus_last_reg, bus_last_next;
	always_comb begin
		bus_last_next = bus_c;
		bus_cnt_next = '0;
		if (bus_c == bus_last_reg && bus_cnt_reg < CW'(SLEEPQ_CYC))
			bus_cnt_next = bus_cnt_reg + CW'(1);
		else if (bus_c == bus_last_reg)
			bus_cnt_next = bus_cnt_reg;
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			bus_cnt_reg <= '0;
			bus_last_reg <= 1'b0;
		end else begin
			bus_cnt_reg <= bus_cnt_next;
			bus_last_reg <= bus_last_next;
		end
	end

	// fault latches, flags, allow bits, threshold register, mode
	logic ovf_reg, ovf_next, lowf_reg, lowf_next, cocf_reg, cocf_next;
	logic docf_reg, docf_next;
	logic ov_lat_reg, ov_lat_next, uv_lat_reg, uv_lat_next;
	logic coc_lat_reg, coc_lat_next, doc_lat_reg, doc_lat_next;
	logic callow_reg, callow_next, dallow_reg, dallow_next;
	logic [7:0] thr_reg, thr_next;
	logic cg_reg, cg_next, dg_reg, dg_next;
	logic [7:0] rd_next;
	logic wr_prot, wr_thr, to_sleep, to_active;
	assign wr_prot = reg_wr_i && reg_addr_i == `CPC_PROT_ADDR;
	assign wr_thr = reg_wr_i && reg_addr_i == `CPC_THR_ADDR;

	always_comb begin
		mode_next = mode_reg;
		to_sleep = 1'b0;
		to_active = 1'b0;
		ov_lat_next = ov_lat_reg;
		uv_lat_next = uv_lat_reg;
		coc_lat_next = coc_lat_reg;
		doc_lat_next = doc_lat_reg;
		ovf_next = ovf_reg;
		lowf_next = lowf_reg;
		cocf_next = cocf_reg;
		docf_next = docf_reg;
		callow_next = callow_reg;
		dallow_next = dallow_reg;
		thr_next = wr_thr ? reg_wdata_i : thr_reg;
		// software clears by writing 0; a same-cycle set still wins
		if (wr_prot) begin
			ovf_next = ovf_reg & reg_wdata_i[`CPC_BIT_HIGH];
			cocf_next = cocf_reg & reg_wdata_i[`CPC_BIT_CSURGE];
			docf_next = docf_reg & reg_wdata_i[`CPC_BIT_DSURGE];
			callow_next = reg_wdata_i[`CPC_BIT_CALLOW];
			dallow_next = reg_wdata_i[`CPC_BIT_DALLOW];
		end
		if (uvclr_c)
			lowf_next = 1'b0;
		case (mode_reg)
			cpc_pkg::CPC_ACTIVE: begin
				if (ov_qual) begin
					ov_lat_next = 1'b1;
					ovf_next = 1'b1;
				end else if (ov_lat_reg && (ce_c || (dis_c && !ov_c)))
					ov_lat_next = 1'b0;
				if (qual[0]) begin
					uv_lat_next = 1'b1;
					lowf_next = 1'b1;
				end else if (uv_lat_reg && !uv_c)
					uv_lat_next = 1'b0;
				if (qual[1]) begin
					coc_lat_next = 1'b1;
					cocf_next = 1'b1;
				end else if (coc_lat_reg && plo_c)
					coc_lat_next = 1'b0;
				if (qual[2] || qual[3]) begin
					doc_lat_next = 1'b1;
					docf_next = 1'b1;
				end else if (doc_lat_reg && phi_c)
					doc_lat_next = 1'b0;
				if (qual[0] && lsa_c &&
						bus_cnt_reg >= CW'(SLEEPQ_CYC)) begin
					mode_next = cpc_pkg::CPC_SLEEP;
					to_sleep = 1'b1;
				end
			end
			cpc_pkg::CPC_SLEEP: begin
				if ((chg_c && !uv_c) || bus_c != bus_last_reg) begin
					mode_next = cpc_pkg::CPC_ACTIVE;
					to_active = 1'b1;
				end
			end
			default: mode_next = cpc_pkg::CPC_ACTIVE;
		endcase
		if (to_sleep) begin
			ovf_next = 1'b0;
			cocf_next = 1'b0;
			docf_next = 1'b0;
		end
		if (to_active) begin
			callow_next = 1'b1;
			dallow_next = 1'b1;
			ov_lat_next = 1'b0;
			uv_lat_next = 1'b0;
			coc_lat_next = 1'b0;
			doc_lat_next = 1'b0;
		end
		// gate drive is off throughout Sleep
		cg_next = active && !to_sleep && !ov_lat_next && !uv_lat_next &&
			!coc_lat_next && callow_next;
		dg_next = active && !to_sleep && !uv_lat_next && !coc_lat_next &&
			!doc_lat_next && dallow_next;
		rd_next = {ovf_next, lowf_next, cocf_next, docf_next, cg_next,
			dg_next, callow_next, dallow_next};
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mode_reg <= cpc_pkg::CPC_ACTIVE;
			ov_lat_reg <= 1'b0;
			uv_lat_reg <= 1'b0;
			coc_lat_reg <= 1'b0;
			doc_lat_reg <= 1'b0;
			ovf_reg <= 1'b0;
			lowf_reg <= 1'b0;
			cocf_reg <= 1'b0;
			docf_reg <= 1'b0;
			callow_reg <= 1'b1;
			dallow_reg <= 1'b1;
			thr_reg <= `CPC_THR_RESET;
			cg_reg <= 1'b0;
			dg_reg <= 1'b0;
		end else begin
			mode_reg <= mode_next;
			ov_lat_reg <= ov_lat_next;
			uv_lat_reg <= uv_lat_next;
			coc_lat_reg <= coc_lat_next;
			doc_lat_reg <= doc_lat_next;
			ovf_reg <= ovf_next;
			lowf_reg <= lowf_next;
			cocf_reg <= cocf_next;
			docf_reg <= docf_next;
			callow_reg <= callow_next;
			dallow_reg <= dallow_next;
			thr_reg <= thr_next;
			cg_reg <= cg_next;
			dg_reg <= dg_next;
		end
	end

	// registered side outputs
	logic pd_reg, pu_reg, rcp_reg, slp_reg;
	logic [7:0] rdat_reg;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pd_reg <= 1'b0;
			pu_reg <= 1'b0;
			rcp_reg <= 1'b0;
			slp_reg <= 1'b0;
			rdat_reg <= '0;
		end else begin
			pd_reg <= coc_lat_next;
			pu_reg <= doc_lat_next;
			rcp_reg <= rc_c;
			slp_reg <= (mode_next == cpc_pkg::CPC_SLEEP);
			rdat_reg <= (reg_addr_i == `CPC_THR_ADDR) ? thr_next :
				(reg_addr_i == `CPC_PROT_ADDR) ? rd_next : 8'h00;
		end
	end

	assign reg_rdata_o = rdat_reg;
	assign charge_gate_out_o = cg_reg;
	assign drain_gate_out_o = dg_reg;
	assign pack_pulldown_o = pd_reg;
	assign pack_pullup_o = pu_reg;
	assign recovery_path_o = rcp_reg;
	assign status_low_cell_flag_o = lowf_reg;
	assign sleep_o = slp_reg;
	assign high_limit_sel_o = thr_reg[7:3];
	assign short_limit_sel_o = thr_reg[2];
	assign surge_limit_sel_o = thr_reg[1:0];
endmodule

// ===== hdl/cpc_params.svh
// register offsets, field positions, reset values, delay times in microseconds and their cycle conversion
// assumes a 25 MHz core clock
`ifndef CPC_PARAMS_SVH
`define CPC_PARAMS_SVH
`define CPC_PROT_ADDR 8'h00
`define CPC_THR_ADDR 8'h7F
`define CPC_BIT_HIGH 7
`define CPC_BIT_LOW 6
`define CPC_BIT_CSURGE 5
`define CPC_BIT_DSURGE 4
`define CPC_BIT_CGATE 3
`define CPC_BIT_DGATE 2
`define CPC_BIT_CALLOW 1
`define CPC_BIT_DALLOW 0
`define CPC_THR_RESET 8'h00
`define CPC_CLK_HZ 25000000
`define CPC_OVD_US 1000
`define CPC_UVD_US 1000
`define CPC_OCD_US 10
`define CPC_SCD_US 1
`define CPC_SLEEPQ_US 2000000
`define CPC_US2CYC(us) ((us) * (`CPC_CLK_HZ / 1000000))
`endif

// ===== hdl/cpc_pkg.sv
// types shared by the protection controller
// constants live in cpc_params.svh
package cpc_pkg;
	typedef enum logic [1:0] {
		CPC_ACTIVE = 2'b01,
		CPC_SLEEP = 2'b10
	} cpc_mode_t;
endpackage

// ===== dv/cpc_protect_monitor.sv
// port checker for the protection controller
// assumes the short delay parameters that the bench sets
`timescale 1ns/10ps
module cpc_protect_monitor #(
	parameter int OVD_CYC = 4,
	parameter int OCD_CYC = 4
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cell_above_high_i,
	input wire logic sense_charge_surge_i,
	input wire logic sense_discharge_surge_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic charge_gate_out_o,
	input wire logic drain_gate_out_o,
	input wire logic pack_pullup_o,
	input wire logic sleep_o,
	input wire logic [4:0] high_limit_sel_o,
	input wire logic short_limit_sel_o,
	input wire logic [1:0] surge_limit_sel_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// eight held cycles cover sync stages plus the short sim delay
	sequence s_high;
		cell_above_high_i [*8];
	endsequence
	sequence s_csurge;
		sense_charge_surge_i [*8];
	endsequence
	sequence s_dsurge;
		sense_discharge_surge_i [*8];
	endsequence
	sequence s_wr_prot;
		reg_wr_i && reg_addr_i == 8'h00;
	endsequence
	sequence s_wr_thr;
		reg_wr_i && reg_addr_i == 8'h7F;
	endsequence
	chk_high_charge_off: assert property (
		s_high |-> ##[0:OVD_CYC] !charge_gate_out_o)
		else $error("charge gate on under overvoltage");
	chk_csurge_both_off: assert property (
		s_csurge |-> ##[0:OCD_CYC]
		(!charge_gate_out_o && !drain_gate_out_o))
		else $error("gates on under charge surge");
	chk_dsurge_drain_off: assert property (
		s_dsurge |-> ##[0:OCD_CYC] !drain_gate_out_o)
		else $error("drain gate on under discharge surge");
	chk_callow_forces_low: assert property (
		s_wr_prot and !reg_wdata_i[1] |=> !charge_gate_out_o)
		else $error("charge gate on with allow clear");
	chk_dallow_forces_low: assert property (
		s_wr_prot and !reg_wdata_i[0] |=> !drain_gate_out_o)
		else $error("drain gate on with allow clear");
	chk_thr_fields_out: assert property (
		s_wr_thr |=> {high_limit_sel_o, short_limit_sel_o,
		surge_limit_sel_o} == $past(reg_wdata_i))
		else $error("threshold fields wrong");
	chk_thr_read_back: assert property (
		(reg_addr_i == 8'h7F && !reg_wr_i) |=> reg_rdata_o ==
		{high_limit_sel_o, short_limit_sel_o, surge_limit_sel_o})
		else $error("threshold read wrong");
	chk_sleep_gates_off: assert property (
		sleep_o |-> !charge_gate_out_o && !drain_gate_out_o)
		else $error("gate on in sleep");
	chk_pullup_drain_off: assert property (
		$rose(pack_pullup_o) |-> ##[0:2] !drain_gate_out_o)
		else $error("pullup with drain on");
endmodule
bind cpc_protect cpc_protect_monitor #(.OVD_CYC(OVD_CYC),
	.OCD_CYC(OCD_CYC)) i_mon (.clk_i, .rst_i, .cell_above_high_i,
	.sense_charge_surge_i, .sense_discharge_surge_i, .reg_wr_i,
	.reg_addr_i, .reg_wdata_i, .reg_rdata_o, .charge_gate_out_o,
	.drain_gate_out_o, .pack_pullup_o, .sleep_o, .high_limit_sel_o,
	.short_limit_sel_o, .surge_limit_sel_o);

// ===== dv/cpc_fet_model.sv
// pack terminal as seen through the external fets under test current
// assumes charger and load presence come from the bench
`timescale 1ns/10ps
module cpc_fet_model (
	input wire logic pulldown_i,
	input wire logic pullup_i,
	input wire logic charger_on_i,
	input wire logic load_on_i,
	output logic pack_low_o,
	output logic pack_high_o
);
	// a party still attached overpowers the weak test current
	assign pack_low_o = pulldown_i && !charger_on_i;
	assign pack_high_o = pullup_i && !load_on_i;
endmodule

// ===== dv/cell_protection_controller_bench.sv
// self-checking bench for the protection controller
// assumes short delay parameters; reads are checked from a queue
`timescale 1ns/10ps
module cell_protection_controller_bench;
	logic clk_i = 0, rst_i = 1, ah = 0, ce = 0, lo = 0, rc = 0, dis = 0;
	logic cs = 0, ds = 0, sh = 0, chg = 0, bus = 1, lsa = 0, slc = 0;
	logic wr_i = 0, rv = 0, plug = 1, load = 1, ppl, pph;
	logic cg, dg, pd, pu, rp, lf, sl, ss;
	logic [7:0] addr = 0, wd = 0, rdo, v;
	logic [4:0] hl;
	logic [1:0] sv;
	logic [31:0] s = 32'h60;
	logic [7:0] q[$];
	int errors = 0, num_checks = 0, cnt = 0;
	always #20 clk_i = ~clk_i;
	cpc_protect #(.OVD_CYC(4), .UVD_CYC(4), .OCD_CYC(4), .SCD_CYC(4),
		.SLEEPQ_CYC(8)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
		.cell_above_high_i(ah), .cell_below_ce_i(ce), .cell_below_low_i(lo),
		.cell_below_rc_i(rc), .sense_charge_surge_i(cs),
		.sense_discharge_surge_i(ds), .sense_short_i(sh),
		.sense_discharging_i(dis), .pack_plus_low_i(ppl),
		.pack_plus_high_i(pph), .charger_seen_i(chg), .bus_line_i(bus),
		.low_cell_sleep_allow_i(lsa), .status_low_clear_i(slc),
		.reg_wr_i(wr_i), .reg_addr_i(addr), .reg_wdata_i(wd),
		.reg_rdata_o(rdo), .charge_gate_out_o(cg), .drain_gate_out_o(dg),
		.pack_pulldown_o(pd), .pack_pullup_o(pu), .recovery_path_o(rp),
		.status_low_cell_flag_o(lf), .sleep_o(sl), .high_limit_sel_o(hl),
		.short_limit_sel_o(ss), .surge_limit_sel_o(sv));
	cpc_fet_model i_fet (.pulldown_i(pd), .pullup_i(pu), .charger_on_i(plug),
		.load_on_i(load), .pack_low_o(ppl), .pack_high_o(pph));
	function automatic logic [31:0] xs();
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task automatic end_of_test();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#2;
	endtask
	task automatic wr(input logic [7:0] a, d);
		wr_i = 1;
		addr = a;
		wd = d;
		cyc(1);
		wr_i = 0;
		cyc(1);
	endtask
	task automatic rd(input logic [7:0] a, e);
		addr = a;
		q.push_back(e);
		rv = 1;
		cyc(1);
		rv = 0;
		cyc(1);
	endtask
	task automatic chk(input logic [7:0] g, e);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("Error %0t pin %h exp %h", $time, g, e);
		end
	endtask
	// rdata lands one edge after the address, so look just after it
	always @(posedge clk_i) begin
		if (rv === 1'b1) begin
			#1;
			chk(rdo, q[0]);
			q.delete(0);
		end
	end
	always @(posedge clk_i) begin
		cnt++;
		if (cnt == 3000) begin
			errors++;
			end_of_test();
		end
	end
	initial begin
		cyc(4);
		rst_i = 0;
		cyc(1);
		rd(8'h00, 8'h0F);
		rd(8'h7F, 8'h00);
		v = xs();
		wr(8'h7F, v);
		wr(8'h33, ~v);
		rd(8'h7F, v);
		chk({hl, ss, sv}, v);
		ah = 1;
		cyc(20);
		ah = 0;
		rd(8'h00, 8'h87);
		chk({cg, dg}, 8'h01);
		dis = 1;
		cyc(10);
		dis = 0;
		rd(8'h00, 8'h8F);
		wr(8'h00, 8'hFF);
		rd(8'h00, 8'h8F);
		wr(8'h00, 8'h7F);
		rd(8'h00, 8'h0F);
		ah = 1;
		cyc(20);
		ah = 0;
		ce = 1;
		cyc(10);
		ce = 0;
		rd(8'h00, 8'h8F);
		wr(8'h00, 8'h7F);
		chk(rp, 8'h00);
		rc = 1;
		cyc(4);
		chk(rp, 1);
		rc = 0;
		for (int k = 0; k < 3; k++) begin
			{cs, ds, sh} = 3'b100 >> k;
			cyc(20);
			{cs, ds, sh} = 0;
			rd(8'h00, k ? 8'h1B : 8'h23);
			wr(8'h00, 8'h0F);
			rd(8'h00, k ? 8'h0B : 8'h03);
			chk({pd, pu}, k ? 8'h01 : 8'h02);
			{plug, load} = 2'b00;
			cyc(10);
			rd(8'h00, 8'h0F);
			{plug, load} = 2'b11;
		end
		wr(8'h00, 8'h0D);
		rd(8'h00, 8'h05);
		chk({cg, dg}, 8'h01);
		wr(8'h00, 8'h0E);
		rd(8'h00, 8'h0A);
		wr(8'h00, 8'h0F);
		rd(8'h00, 8'h0F);
		lo = 1;
		cyc(20);
		rd(8'h00, 8'h43);
		chk({lf, sl}, 8'h02);
		lo = 0;
		cyc(10);
		rd(8'h00, 8'h4F);
		slc = 1;
		cyc(2);
		slc = 0;
		rd(8'h00, 8'h0F);
		lsa = 1;
		lo = 1;
		cyc(40);
		chk(sl, 1);
		chg = 1;
		cyc(10);
		chk(sl, 1);
		lo = 0;
		cyc(10);
		chg = 0;
		chk(sl, 0);
		rd(8'h00, 8'h4F);
		lo = 1;
		cyc(40);
		chk(sl, 1);
		lo = 0;
		bus = 0;
		cyc(6);
		chk(sl, 0);
		rd(8'h00, 8'h4F);
		end_of_test();
	end
endmodule
